// *** hdl/cnac_arb.sv ***
`timescale 1ns/1ps
module cnac_arb (
  input  wire logic [3:0] req,
  output logic      [3:0] gnt
);
  assign gnt = req & ~(req - 4'h1) ; // lowest index first
endmodule

// *** hdl/cnac_node.sv ***
`timescale 1ns/1ps
module cnac_node (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               restart,
  input  wire logic               enable,
  input  cnac_pkg::cnac_ncfg_s    cfg,
  input  wire logic               lost,
  input  wire logic               bumped,
  input  wire logic               cmd_valid,
  input  wire logic [7:0]         cmd_addr,
  output cnac_pkg::cnac_stat_s    stat,
  output logic                    changed
);
  cnac_pkg::cnac_stat_s next_stat;
  logic [7:0]           wait_cnt;
  logic [7:0]           next_wait;
  wire                  win_done = (wait_cnt == 8'h00);
  wire                  at_end   = (stat.addr == cfg.last) || (stat.addr == 8'hfd);
  always_comb begin
    next_stat = stat;
    next_wait = (wait_cnt != 8'h00) ? wait_cnt - 8'h01 : 8'h00;
    case (stat.st)
      cnac_pkg::CNAC_DISABLED: begin
        if (enable) begin
          next_stat.st = cnac_pkg::CNAC_CLAIMING;
          next_stat.attempts = 8'h01;
          next_stat.addr = cfg.pref;
          next_wait = cnac_pkg::CLAIM_WAIT;
        end
      end
      cnac_pkg::CNAC_CLAIMING: begin
        if (lost || bumped) begin
          if (at_end) begin
            next_stat.st = cnac_pkg::CNAC_FAILED;
            next_stat.addr = cnac_pkg::ADDR_NULL;
          end else begin
            next_stat.addr = stat.addr + 8'h01;
            next_stat.attempts = stat.attempts + 8'h01;
            next_wait = cnac_pkg::CLAIM_WAIT;
          end
        end else if (win_done) begin
          next_stat.st = cnac_pkg::CNAC_CLAIMED;
        end
      end
      cnac_pkg::CNAC_CLAIMED: begin
        if (cmd_valid && cmd_addr < cnac_pkg::ADDR_NULL) begin
          next_stat.st = cnac_pkg::CNAC_CLAIMING;
          next_stat.addr = cmd_addr;
          next_wait = cnac_pkg::CLAIM_WAIT;
        end else if (bumped) begin
          next_stat.st = at_end ? cnac_pkg::CNAC_FAILED : cnac_pkg::CNAC_CLAIMING;
          next_stat.addr = at_end ? cnac_pkg::ADDR_NULL : stat.addr + 8'h01;
          next_stat.attempts = stat.attempts + 8'h01;
          next_wait = cnac_pkg::CLAIM_WAIT;
        end
      end
      cnac_pkg::CNAC_FAILED: ; // stays idle
      default: next_stat.st = cnac_pkg::CNAC_DISABLED;
    endcase
    if (!enable || restart) begin
      next_stat.st = cnac_pkg::CNAC_DISABLED;
      next_stat.attempts = 8'h00;
      next_stat.addr = cnac_pkg::ADDR_NULL;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat     <= '{cnac_pkg::CNAC_DISABLED, 8'h00, 8'hfe};
      wait_cnt <= 8'h00;
      changed  <= 1'b0;
    end else begin
      stat     <= next_stat;
      wait_cnt <= next_wait;
      changed  <= (next_stat.st != stat.st);
    end
  end
  a_disabled_report : assert property (@(posedge clk) disable iff (!rst_b)
    stat.st == cnac_pkg::CNAC_DISABLED |-> stat.attempts == 8'h00 && stat.addr == 8'hfe)
    else $error("disabled status not 0 / 0xfe");
  a_failed_addr : assert property (@(posedge clk) disable iff (!rst_b)
    stat.st == cnac_pkg::CNAC_FAILED |-> stat.addr == 8'hfe)
    else $error("failed status address not 0xfe");
  a_failed_stays : assert property (@(posedge clk) disable iff (!rst_b)
    stat.st == cnac_pkg::CNAC_FAILED && enable && !restart |=>
      stat.st == cnac_pkg::CNAC_FAILED)
    else $error("failed node left failed on its own");
  a_claim_start : assert property (@(posedge clk) disable iff (!rst_b)
    stat.st == cnac_pkg::CNAC_DISABLED && enable && !restart |=>
      stat.st == cnac_pkg::CNAC_CLAIMING && stat.attempts == 8'h01)
    else $error("claim did not start at attempt 1");
  a_change_pulse : assert property (@(posedge clk) disable iff (!rst_b)
    $changed(stat.st) |-> changed)
    else $error("state change not reported");
endmodule

// *** hdl/cnac_pkg.sv ***
// Overview of operation
// - factory defaults: ports off, no claims, NMEA2000
// - default name address 0x1c, group 2, function 23
// - node config and port enable any order
// - claim only when bound port switched on
// - online only after claim succeeded, report address
// - no traffic until claimed; outgoing dropped
// - status gives state, attempt count, address
// - lost attempt moves to next range address
// - range exhausted: failed, address 0xfe, idle
// - bumped by higher priority: claim next address
// - commanded address adopted, claiming then claimed
// - restart discards commanded address
// - nmea2000 requests accepted, emitted only online
// - peer 0xff any/broadcast, else specific peer
// - correction settings leave nmea2000 untouched
// - one traffic type per logical port
// - text mode parses all input as text
// - port enable starts no output alone
// - port on carries bit rate, port runs it
// - port on claims with defaults if unconfigured
// - two buses, two nodes, each own config; both nodes show the same default name
// - lower logical port index wins transmit
package cnac_pkg;
  // ****************************************************************
  // register map (word aligned byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_NCFG0   = 8'h04;
  localparam logic [7:0] ADR_NCFG1   = 8'h08;
  localparam logic [7:0] ADR_STAT0   = 8'h0c;
  localparam logic [7:0] ADR_STAT1   = 8'h10;
  localparam logic [7:0] ADR_LPORT   = 8'h14;
  localparam logic [7:0] ADR_CMD     = 8'h18;
  // peer: byte p is the correction peer of logical port p, 0xff any
  localparam logic [7:0] ADR_PEER    = 8'h1c;
  // ctrl: [0] port0 on, [1] port1 on, [5:4] rate0, [7:6] rate1
  localparam int CTRL_RATE0 = 4;
  localparam int CTRL_RATE1 = 6;
  localparam logic [1:0] RATE_250K = 2'h1;
  // node cfg: [7:0] preferred, [15:8] range end, [16] port, [17] bound
  localparam int NCFG_PORT  = 16;
  localparam int NCFG_BOUND = 17;
  // cmd: [0] factory defaults
  // logical port cfg per port (4 ports, 8 bits each):
  // [0] node, [2:1] mode
  localparam int NLPORT = 4;
  // ****************************************************************
  // defaults
  // ****************************************************************
  localparam logic [7:0] DEF_ADDR     = 8'h1c;
  localparam logic [2:0] DEF_IGROUP   = 3'h2;
  localparam logic [7:0] DEF_FUNC     = 8'h17;
  localparam logic [7:0] ADDR_NULL    = 8'hfe;
  localparam logic [7:0] ADDR_GLOBAL  = 8'hff;
  localparam logic [7:0] CLAIM_WAIT   = 8'h19; // 250 ns arbitrary window
  typedef enum logic [1:0] {
    CNAC_DISABLED, CNAC_CLAIMING, CNAC_CLAIMED, CNAC_FAILED
  } cnac_state_e;
  typedef enum logic [1:0] {
    CNAC_N2K_ONLY, CNAC_BINARY, CNAC_TEXT, CNAC_CORR
  } cnac_mode_e;
  typedef struct packed {
    logic       bound;
    logic       port;
    logic [7:0] last;
    logic [7:0] pref;
  } cnac_ncfg_s;
  typedef struct packed {
    cnac_state_e st;
    logic [7:0]  attempts;
    logic [7:0]  addr;
  } cnac_stat_s;
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } cnac_wb_s;
endpackage

// *** hdl/cnac_top.sv ***
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cnac_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // far side events per node
  input  wire logic [1:0]  claim_lost,
  input  wire logic [1:0]  claim_bumped,
  input  wire logic [1:0]  cmd_addr_valid,
  input  wire logic [15:0] cmd_addr,
  // logical port traffic
  input  wire logic [3:0]  n2k_req,
  input  wire logic [3:0]  app_req,
  input  wire logic [3:0]  rx_frame,
  input  wire logic [7:0]  rx_src,
  output logic [3:0]       tx_grant,
  output logic [3:0]       tx_drop,
  output logic [3:0]       rx_accept,
  output logic [3:0]       rx_text,
  // physical ports
  output logic [1:0]       port_on,
  output logic [3:0]       port_rate,
  output logic [1:0]       status_event
);
  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wr      = wb_req && wb_we_i && wb_sel_i[0];
  wire        wr_ctrl = wr && wb_adr_i == cnac_pkg::ADR_CTRL;
  wire        wr_n0   = wr && wb_adr_i == cnac_pkg::ADR_NCFG0;
  wire        wr_n1   = wr && wb_adr_i == cnac_pkg::ADR_NCFG1;
  wire        wr_lp   = wr && wb_adr_i == cnac_pkg::ADR_LPORT;
  wire        wr_peer = wr && wb_adr_i == cnac_pkg::ADR_PEER;
  wire        wr_fd   = wr && wb_adr_i == cnac_pkg::ADR_CMD && wb_dat_i[0];
  logic [7:0]              ctrl;
  cnac_pkg::cnac_ncfg_s    ncfg [2];
  logic [31:0]             lport;
  logic [31:0]             peer_cfg;
  cnac_pkg::cnac_stat_s    stat [2];
  logic [1:0]              chg;
  logic [1:0]              node_en;
  logic [1:0]              node_rst;
  logic [1:0]              online;
  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // nodes come up bound to their own port so a bare port-on claims
      ctrl     <= 8'h00;
      ncfg[0]  <= '{1'b1, 1'b0, cnac_pkg::DEF_ADDR, cnac_pkg::DEF_ADDR};
      ncfg[1]  <= '{1'b1, 1'b1, cnac_pkg::DEF_ADDR, cnac_pkg::DEF_ADDR};
      lport    <= 32'h0000_0000;
      peer_cfg <= {cnac_pkg::NLPORT{cnac_pkg::ADDR_GLOBAL}};
    end else if (wr_fd) begin
      ctrl     <= 8'h00;
      ncfg[0]  <= '{1'b1, 1'b0, cnac_pkg::DEF_ADDR, cnac_pkg::DEF_ADDR};
      ncfg[1]  <= '{1'b1, 1'b1, cnac_pkg::DEF_ADDR, cnac_pkg::DEF_ADDR};
      lport    <= 32'h0000_0000;
      peer_cfg <= {cnac_pkg::NLPORT{cnac_pkg::ADDR_GLOBAL}};
    end else begin
      if (wr_ctrl) ctrl <= wb_dat_i[7:0];
      if (wr_n0) ncfg[0] <= wb_dat_i[17:0]; // pending until on
      if (wr_n1) ncfg[1] <= wb_dat_i[17:0];
      if (wr_lp) lport <= wb_dat_i;
      if (wr_peer) peer_cfg <= wb_dat_i;
    end
  end
  // ****************************************************************
  // nodes
  // ****************************************************************
  for (genvar n = 0; n < 2; n++) begin : g_node // each node its own config
    assign node_en[n]  = ncfg[n].bound && ctrl[ncfg[n].port];
    assign node_rst[n] = (n == 0) ? wr_n0 : wr_n1;
    assign online[n]   = stat[n].st == cnac_pkg::CNAC_CLAIMED;
    cnac_node u_node (
      .clk       (clk),
      .rst_b     (rst_b),
      .restart   (node_rst[n] || wr_fd),
      .enable    (node_en[n] && !wr_fd),
      .cfg       (ncfg[n]),
      .lost      (claim_lost[n]),
      .bumped    (claim_bumped[n]),
      .cmd_valid (cmd_addr_valid[n]),
      .cmd_addr  (cmd_addr[8*n +: 8]),
      .stat      (stat[n]),
      .changed   (chg[n])
    );
  end
  // ****************************************************************
  // logical port traffic
  // ****************************************************************
  logic [3:0] lp_online;
  logic [3:0] tx_req;
  logic [3:0] gnt;
  logic [3:0] rx_ok;
  logic [3:0] text_m;
  for (genvar p = 0; p < cnac_pkg::NLPORT; p++) begin : g_lp
    wire [1:0] mode = lport[8*p+1 +: 2]; // one mode per port
    wire [7:0] peer = peer_cfg[8*p +: 8]; // own peer byte per port
    assign lp_online[p] = online[lport[8*p]];
    // nmea2000 rides alongside any mode
    assign tx_req[p] = lp_online[p] && (n2k_req[p] ||
                       (app_req[p] && mode != cnac_pkg::CNAC_N2K_ONLY));
    assign rx_ok[p] = lp_online[p] && rx_frame[p] && mode != cnac_pkg::CNAC_N2K_ONLY &&
                      (peer == cnac_pkg::ADDR_GLOBAL || peer == rx_src);
    assign text_m[p] = mode == cnac_pkg::CNAC_TEXT;
  end
  cnac_arb u_arb (
    .req (tx_req),
    .gnt (gnt)
  );
  // ****************************************************************
  // outputs and bus answer
  // ****************************************************************
  // name is fixed at its defaults; shown above the node config
  wire [13:0] name_bits = {cnac_pkg::DEF_IGROUP, cnac_pkg::DEF_FUNC, 3'h0};
  wire [31:0] rd_mux =
    (wb_adr_i == cnac_pkg::ADR_CTRL)  ? {24'h0, ctrl} :
    (wb_adr_i == cnac_pkg::ADR_NCFG0) ? {name_bits, ncfg[0]} :
    (wb_adr_i == cnac_pkg::ADR_NCFG1) ? {name_bits, ncfg[1]} :
    (wb_adr_i == cnac_pkg::ADR_STAT0) ? {14'h0, stat[0]} :
    (wb_adr_i == cnac_pkg::ADR_STAT1) ? {14'h0, stat[1]} :
    (wb_adr_i == cnac_pkg::ADR_LPORT) ? lport :
    (wb_adr_i == cnac_pkg::ADR_PEER)  ? peer_cfg : 32'h0000_0000;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
      tx_grant     <= 4'h0;
      tx_drop      <= 4'h0;
      rx_accept    <= 4'h0;
      rx_text      <= 4'h0;
      port_on      <= 2'h0;
      port_rate    <= 4'h0;
      status_event <= 2'h0;
    end else begin
      wb_ack_o     <= wb_req;
      wb_dat_o     <= wb_req ? rd_mux : 32'h0000_0000;
      tx_grant     <= gnt;
      tx_drop      <= (n2k_req | app_req) & ~lp_online; // dropped, never queued
      rx_accept    <= rx_ok;
      rx_text      <= rx_ok & text_m;
      port_on      <= ctrl[1:0];
      port_rate    <= {ctrl[cnac_pkg::CTRL_RATE1 +: 2], ctrl[cnac_pkg::CTRL_RATE0 +: 2]};
      status_event <= chg;
    end
  end
  a_no_tx_offline : assert property (@(posedge clk) disable iff (!rst_b)
    |tx_grant |-> $past(|(tx_req))) else $error("grant without online request");
  a_grant_onehot : assert property (@(posedge clk) disable iff (!rst_b)
    $onehot0(tx_grant)) else $error("more than one grant");
  a_ack_one : assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule

// *** verif/can_node_address_claim_tb.sv ***
`timescale 1ns/1ps
module can_node_address_claim_tb;
  // ****
  // bench signals
  // ****
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  claim_lost, claim_bumped, cmd_addr_valid;
  logic [15:0] cmd_addr;
  logic [3:0]  n2k_req = 4'h0;
  logic [3:0]  app_req = 4'h0;
  logic [3:0]  rx_frame = 4'h0;
  logic [7:0]  rx_src = 8'hff;
  logic [3:0]  tx_grant, tx_drop, rx_accept, rx_text, port_rate;
  logic [1:0]  port_on, status_event;
  int          errors = 0;
  int          n_tests = 0;
  int          ev_cnt = 0;
  int          ev_cnt1 = 0;
  localparam logic [31:0] SA = 32'h0003_00ff;
  always #5 clk = ~clk;
  always @(posedge clk) if (status_event[0] === 1'b1) ev_cnt++;
  always @(posedge clk) if (status_event[1] === 1'b1) ev_cnt1++;
  cnac_top dut_u (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .claim_lost, .claim_bumped, .cmd_addr_valid,
    .cmd_addr, .n2k_req, .app_req, .rx_frame, .rx_src, .tx_grant, .tx_drop,
    .rx_accept, .rx_text, .port_on, .port_rate, .status_event);
  cnac_far_unit far_u (.clk, .rst_b, .claim_lost, .claim_bumped, .cmd_addr_valid,
    .cmd_addr);
  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // a hung slave is ended by the watchdog
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hffffffff);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    cmp(x & m, exp);
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    cmp({28'h0, got}, {28'h0, exp});
  endtask
  task automatic rx_pulse(input logic [7:0] src, input logic [3:0] acc,
                          input logic [3:0] txt);
    rx_src   <= src;
    rx_frame <= 4'h1;
    @(posedge clk);
    rx_frame <= 4'h0;
    @(posedge clk);
    chk_pin(rx_accept, acc);
    chk_pin(rx_text, txt);
  endtask
  function automatic logic [31:0] st(input logic [1:0] s, input logic [7:0] n,
                                     input logic [7:0] a);
    return {14'h0, s, n, a};
  endfunction
  // ****
  // sequence
  // ****
  initial begin
    #50us;
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h0, 8'h00, 8'hfe));
    chk_rd(cnac_pkg::ADR_CTRL, 32'h0);
    chk_rd(8'hfc, 32'h0);
    chk_rd(cnac_pkg::ADR_NCFG0, 32'h42e2_1c1c);
    n2k_req <= 4'h1;
    wr(cnac_pkg::ADR_NCFG0, 32'h0002_1e30);
    wr(cnac_pkg::ADR_NCFG0, 32'h0002_1e1c);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h0, 8'h00, 8'hfe));
    chk_pin(tx_drop, 4'h1);
    chk_pin(tx_grant, 4'h0);
    wr(cnac_pkg::ADR_CTRL, 32'h11);
    chk_pin({2'h0, port_on}, 4'h1);
    chk_pin(port_rate, 4'h1);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h1, 8'h01, 8'h1c));
    repeat (30) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h2, 8'h01, 8'h1c));
    cmp(ev_cnt, 2);
    chk_pin(tx_grant, 4'h1);
    chk_pin(tx_drop, 4'h0);
    n2k_req <= 4'h6;
    repeat (2) @(posedge clk);
    chk_pin(tx_grant, 4'h2);
    n2k_req <= 4'h0;
    wr(cnac_pkg::ADR_LPORT, 32'h0000_0006);
    rx_pulse(8'hff, 4'h1, 4'h0);
    wr(cnac_pkg::ADR_PEER, 32'hffff_ff1c);
    rx_pulse(8'h30, 4'h0, 4'h0);
    rx_pulse(8'h1c, 4'h1, 4'h0);
    wr(cnac_pkg::ADR_LPORT, 32'h0000_0004);
    rx_pulse(8'h1c, 4'h1, 4'h1);
    n2k_req <= 4'h1;
    app_req <= 4'h2;
    repeat (2) @(posedge clk);
    chk_pin(tx_grant, 4'h1);
    n2k_req <= 4'h0;
    app_req <= 4'h3;
    repeat (2) @(posedge clk);
    chk_pin(tx_grant, 4'h1);
    app_req <= 4'h0;
    far_u.ev(1, 0, 8'h00, 0);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h1, 8'h00, 8'h1d), SA);
    far_u.ev(0, 0, 8'h00, 3);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h1, 8'h00, 8'h1e), SA);
    far_u.ev(0, 0, 8'h00, 1);
    repeat (40) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h3, 8'h00, 8'hfe), SA);
    wr(cnac_pkg::ADR_CTRL, 32'h10);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h0, 8'h00, 8'hfe));
    wr(cnac_pkg::ADR_NCFG0, 32'h0002_1e1c);
    wr(cnac_pkg::ADR_CTRL, 32'h11);
    repeat (30) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h2, 8'h00, 8'h1c), SA);
    far_u.ev(2, 0, 8'h40, 0);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h1, 8'h00, 8'h40), SA);
    repeat (30) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h2, 8'h00, 8'h40), SA);
    wr(cnac_pkg::ADR_CTRL, 32'h10);
    wr(cnac_pkg::ADR_CTRL, 32'h11);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h1, 8'h01, 8'h1c));
    wr(cnac_pkg::ADR_NCFG1, 32'h0003_2a2a);
    wr(cnac_pkg::ADR_CTRL, 32'h13);
    chk_pin({2'h0, port_on}, 4'h3);
    repeat (30) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT1, st(2'h2, 8'h00, 8'h2a), SA);
    cmp(ev_cnt1, 2);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h2, 8'h00, 8'h1c), SA);
    wr(cnac_pkg::ADR_CMD, 32'h1);
    chk_rd(cnac_pkg::ADR_CTRL, 32'h0);
    chk_rd(cnac_pkg::ADR_LPORT, 32'h0);
    chk_rd(cnac_pkg::ADR_STAT1, st(2'h0, 8'h00, 8'hfe));
    chk_rd(cnac_pkg::ADR_PEER, 32'hffff_ffff);
    chk_rd(cnac_pkg::ADR_NCFG1, 32'h42e3_1c1c);
    wr(cnac_pkg::ADR_CTRL, 32'h11);
    repeat (30) @(posedge clk);
    chk_rd(cnac_pkg::ADR_STAT0, st(2'h2, 8'h00, 8'h1c), SA);
    chk_pin(tx_grant, 4'h0);
    tally_and_finish();
  end
endmodule

// *** verif/cnac_far_unit.sv ***
`timescale 1ns/1ps
module cnac_far_unit (
  input  wire logic clk,
  input  wire logic rst_b,
  output logic [1:0]  claim_lost,
  output logic [1:0]  claim_bumped,
  output logic [1:0]  cmd_addr_valid,
  output logic [15:0] cmd_addr
);
  // ****
  // other control units on the bus
  // ****
  logic [1:0]  req_l = 2'h0;
  logic [1:0]  req_b = 2'h0;
  logic [1:0]  req_c = 2'h0;
  logic [15:0] req_a = 16'h0000;
  // requests are posted on the falling edge so the pulse launch never races the bench
  task automatic ev(input int kind, input int n, input logic [7:0] a, input int dly);
    repeat (dly) @(negedge clk);
    @(negedge clk);
    if (kind == 0) req_l[n] = 1'b1;
    if (kind == 1) req_b[n] = 1'b1;
    if (kind == 2) begin
      req_c[n] = 1'b1;
      req_a[8*n+:8] = a;
    end
    repeat (2) @(posedge clk); // let the node act before the caller looks
  endtask
  // address lines toggle when no command is offered, so stale values never look valid
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      claim_lost     <= 2'h0;
      claim_bumped   <= 2'h0;
      cmd_addr_valid <= 2'h0;
      cmd_addr       <= 16'h5a5a;
    end else begin
      claim_lost     <= req_l;
      claim_bumped   <= req_b;
      cmd_addr_valid <= req_c;
      cmd_addr       <= (|req_c) ? req_a : ~cmd_addr;
      req_l = 2'h0;
      req_b = 2'h0;
      req_c = 2'h0;
    end
  end
endmodule
